// File: logic/urb_cfg.svh
`ifndef URB_CFG_SVH
`define URB_CFG_SVH
`define URB_REG_STATUS 2'h0
`define URB_REG_CTRL 2'h1
`define URB_REG_FORMAT 2'h2
`define URB_REG_DATA 2'h3
`define URB_ST_COMPLETE 7
`define URB_ST_STOPERR 4
`define URB_ST_OVERRUN 3
`define URB_ST_PARERR 2
`define URB_CT_IRQEN 7
`define URB_CT_RECEIVER_ENABLE 4
`define URB_CT_NINTH 1
`define URB_FM_PAREN 5
`define URB_FM_PARODD 4
`define URB_FM_STOPSEL 3
`define URB_FM_SIZE_HI 2
`define URB_FM_SIZE_LO 1
`define URB_FM_RESET 8'h06
`define URB_SIZE_NINE 3'h7
`define URB_OVERSAMPLE 16
`define URB_VOTE_MID 8
`endif

// File: logic/urb_pkg.sv
package urb_pkg;
  typedef enum logic [2:0] {
    URB_IDLE = 3'h0,
    URB_START = 3'h1,
    URB_DATA = 3'h3,
    URB_PAR = 3'h2,
    URB_STOP = 3'h6
  } urb_rx_state_type;

  typedef struct packed {
    logic [8:0] data;
    logic stop_err;
    logic overrun;
    logic par_err;
  } urb_entry_type;
endpackage : urb_pkg

// File: logic/urb_fifo.sv
`timescale 1ns/1ps
`include "urb_cfg.svh"
module urb_fifo #(
  parameter int DEPTH = 2
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic push_i,
  input urb_pkg::urb_entry_type push_data_i,
  input wire logic pop_i,
  output urb_pkg::urb_entry_type head_o,
  output logic [1:0] count_o
);
  import urb_pkg::*;

  typedef struct packed {
    urb_entry_type [DEPTH-1:0] mem;
    logic [1:0] count;
  } urb_fifo_state_type;

  urb_fifo_state_type s_reg;
  urb_fifo_state_type s_next;

  always_comb begin
    logic do_pop;
    logic do_push;
    do_pop = pop_i && (s_reg.count != 2'h0);
    do_push = push_i && (s_reg.count != 2'(DEPTH) || do_pop);
    s_next = s_reg;
    if (do_pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        s_next.mem[i] = s_reg.mem[i+1];
      end
      s_next.count = s_reg.count - 2'h1;
    end
    if (do_push) begin
      s_next.mem[s_next.count] = push_data_i;
      s_next.count = s_next.count + 2'h1;
    end
    if (flush_i) begin
      s_next.count = 2'h0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign head_o = s_reg.mem[0];
  assign count_o = s_reg.count;
endmodule : urb_fifo

// File: logic/urb_receiver.sv
`timescale 1ns/1ps
`include "urb_cfg.svh"
module urb_receiver #(
  parameter int DEPTH = 2,
  parameter int OVERSAMPLE = `URB_OVERSAMPLE
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic sample_en_i,
  input wire logic rx_pin_i,
  input wire logic global_irq_en_i,
  output logic rx_irq_o,
  output logic pin_override_o
);
  import urb_pkg::*;

  typedef struct packed {
    logic [7:0] rdata;
    logic irq;
    logic ovr;
    logic rx_en;
    logic irq_en;
    logic [7:0] fmt;
    urb_rx_state_type st;
    logic [4:0] tick;
    logic [3:0] bitn;
    logic [8:0] shift;
    logic par_bit;
    logic [2:0] votes;
    logic held;
    urb_entry_type held_e;
  } urb_state_type;

  urb_state_type s_reg;
  urb_state_type s_next;
  urb_entry_type head;
  logic [1:0] count;
  logic push;
  logic pop;
  logic flush;
  urb_entry_type push_e;

  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : majority

  function automatic logic [3:0] data_bits(input logic [2:0] size);
    if (size == `URB_SIZE_NINE) begin
      data_bits = 4'h9;
    end else begin
      data_bits = 4'h5 + {1'b0, size[2:0] > 3'h3 ? 3'h3 : size};
    end
  endfunction : data_bits

  function automatic logic [8:0] mask_data(input logic [8:0] d,
                                           input logic [3:0] n);
    mask_data = d & ((9'h1 << n) - 9'h1);
  endfunction : mask_data

  urb_fifo #(
    .DEPTH(DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(flush),
    .push_i(push),
    .push_data_i(push_e),
    .pop_i(pop),
    .head_o(head),
    .count_o(count)
  );

  always_comb begin
    logic [2:0] size;
    logic [3:0] nbits;
    logic bit_v;
    logic mid;
    logic full;
    logic [7:0] status;
    size = {1'b0, s_reg.fmt[`URB_FM_SIZE_HI:`URB_FM_SIZE_LO]};
    nbits = data_bits(size);
    s_next = s_reg;
    push = 1'b0;
    push_e = s_reg.held_e;
    pop = 1'b0;
    flush = 1'b0;
    bit_v = majority(s_reg.votes);
    mid = 1'b0;
    full = (count == 2'(DEPTH));
    status = 8'h00;
    status[`URB_ST_COMPLETE] = (count != 2'h0);
    status[`URB_ST_STOPERR] = (count != 2'h0) && head.stop_err;
    status[`URB_ST_OVERRUN] = (count != 2'h0) && head.overrun;
    status[`URB_ST_PARERR] = (count != 2'h0) && head.par_err &&
                             s_reg.fmt[`URB_FM_PAREN];
    s_next.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `URB_REG_STATUS: s_next.rdata = status;
        `URB_REG_CTRL: begin
          s_next.rdata[`URB_CT_IRQEN] = s_reg.irq_en;
          s_next.rdata[`URB_CT_RECEIVER_ENABLE] = s_reg.rx_en;
          s_next.rdata[`URB_CT_NINTH] = head.data[8] && (count != 2'h0);
        end
        `URB_REG_FORMAT: s_next.rdata = s_reg.fmt;
        `URB_REG_DATA: begin
          s_next.rdata = (count != 2'h0) ? head.data[7:0] : 8'h00;
          pop = 1'b1;
        end
        default: s_next.rdata = 8'h00;
      endcase
    end
    if (wr_i) begin
      case (addr_i)
        `URB_REG_CTRL: begin
          s_next.irq_en = wdata_i[`URB_CT_IRQEN];
          s_next.rx_en = wdata_i[`URB_CT_RECEIVER_ENABLE];
        end
        `URB_REG_FORMAT: s_next.fmt = wdata_i & 8'h3e;
        default: s_next.fmt = s_next.fmt;
      endcase
    end
    // stored frame moves into buffer once room appears
    if (s_reg.held && (!full || pop)) begin
      push = 1'b1;
      push_e.overrun = s_reg.ovr;
      s_next.held = 1'b0;
      s_next.ovr = 1'b0;
    end
    if (s_reg.rx_en && sample_en_i) begin
      s_next.tick = s_reg.tick + 5'h1;
      if (s_reg.tick[3:0] >= 4'(`URB_VOTE_MID - 1) &&
          s_reg.tick[3:0] <= 4'(`URB_VOTE_MID + 1)) begin
        s_next.votes = {s_reg.votes[1:0], rx_pin_i};
      end
      mid = (s_reg.tick == 5'(OVERSAMPLE - 1));
      if (mid) begin
        s_next.tick = 5'h0;
      end
      case (s_reg.st)
        URB_IDLE: begin
          s_next.tick = 5'h0;
          if (!rx_pin_i) begin
            s_next.st = URB_START;
            s_next.tick = 5'h1;
            if (full && s_reg.held) begin
              s_next.ovr = 1'b1;
            end
          end
        end
        URB_START: if (mid) begin
          s_next.st = bit_v ? URB_IDLE : URB_DATA;
          s_next.bitn = 4'h0;
          s_next.shift = 9'h0;
        end
        URB_DATA: if (mid) begin
          s_next.shift[s_reg.bitn] = bit_v;
          s_next.bitn = s_reg.bitn + 4'h1;
          if (s_reg.bitn == nbits - 4'h1) begin
            s_next.st = s_reg.fmt[`URB_FM_PAREN] ? URB_PAR : URB_STOP;
          end
        end
        URB_PAR: if (mid) begin
          s_next.par_bit = bit_v;
          s_next.st = URB_STOP;
        end
        URB_STOP: if (mid) begin
          s_next.st = URB_IDLE;
          s_next.held_e.data = mask_data(s_reg.shift, nbits);
          s_next.held_e.stop_err = !bit_v;
          s_next.held_e.par_err = s_reg.fmt[`URB_FM_PAREN] &&
            ((^s_reg.shift) ^ s_reg.par_bit ^ s_reg.fmt[`URB_FM_PARODD]);
          s_next.held_e.overrun = 1'b0;
          if (s_reg.held && !push) begin
            s_next.ovr = 1'b1;
          end
          s_next.held = 1'b1;
        end
        default: s_next.st = URB_IDLE;
      endcase
    end
    if (!s_reg.rx_en) begin
      flush = 1'b1;
      s_next.st = URB_IDLE;
      s_next.held = 1'b0;
      s_next.ovr = 1'b0;
      s_next.tick = 5'h0;
    end
    s_next.irq = s_next.irq_en && global_irq_en_i && s_next.rx_en &&
                 ((count != 2'h0 && !(pop && count == 2'h1)) || push);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
      s_reg.fmt <= `URB_FM_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_o = s_reg.rdata;
  assign rx_irq_o = s_reg.irq;
  assign pin_override_o = s_reg.rx_en;
endmodule : urb_receiver

// File: test/urb_receiver_asserts.sv
`timescale 1ns/1ps
module urb_chk (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic global_irq_en_i,
  input wire logic rx_irq_o,
  input wire logic pin_override_o
);
  // last written irq enable, receiver enable, parity enable
  logic [2:0] m_reg;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      m_reg <= 3'h0;
    end else if (wr_i && addr_i == 2'h1) begin
      m_reg[2:1] <= {wdata_i[7], wdata_i[4]};
    end else if (wr_i && addr_i == 2'h2) begin
      m_reg[0] <= wdata_i[5];
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_irq_cause: assert property (
    rx_irq_o |-> $past(global_irq_en_i) && m_reg[2] && m_reg[1])
    else $error("irq");
  a_irq_hold: assert property (
    rx_irq_o && global_irq_en_i && !(rd_i || wr_i) |=> rx_irq_o)
    else $error("irq dropped");
  a_flag_set: assert property (
    rd_i && addr_i == 2'h0 && rx_irq_o && !$past(rd_i || wr_i)
    |=> rdata_o[7]) else $error("flag");
  a_rdata_idle: assert property (
    !$past(rd_i) |-> rdata_o == 8'h00) else $error("rdata");
  a_rx_override: assert property (
    (wr_i && addr_i == 2'h1) ##1 !(wr_i && addr_i == 2'h1)
    |=> pin_override_o == $past(wdata_i[4], 2)) else $error("override");
  a_off_no_irq: assert property (
    $fell(pin_override_o) |=> !rx_irq_o) else $error("irq off");
  a_disable_flush: assert property (
    (wr_i && addr_i == 2'h1 && !wdata_i[4]) ##2 (rd_i && addr_i == 2'h0)
    |=> !rdata_o[7]) else $error("flush");
  a_parity_off: assert property (
    rd_i && addr_i == 2'h0 && !m_reg[0] |=> !rdata_o[2])
    else $error("parity");
  a_ctrl_read: assert property (
    rd_i && addr_i == 2'h1 |=> rdata_o[7] == m_reg[2]) else $error("ctrl");
  c_irq: cover property (rx_irq_o);
  c_off: cover property ($fell(pin_override_o));
  c_data: cover property (rd_i && addr_i == 2'h3 ##1 rdata_o != 8'h00);
endmodule : urb_chk
bind urb_receiver urb_chk i_urb_chk (.core_clk_i, .rst_n_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .global_irq_en_i, .rx_irq_o,
  .pin_override_o);

// File: test/urb_tx_model.sv
`timescale 1ns/1ps
module urb_tx_model (
  input wire logic core_clk_i,
  output logic line_o
);
  initial line_o = 1'b1;
  // start, data lsb first, parity if pe, one stop bit, then idle high
  task automatic send(input logic [7:0] d, input logic p, input logic s,
    input logic pe);
    logic [10:0] b;
    b = pe ? {s, p, d, 1'b0} : {1'b1, s, d, 1'b0};
    for (int i = 0; i < (pe ? 11 : 10); i++) begin
      line_o <= b[i];
      repeat (16) @(posedge core_clk_i);
    end
    line_o <= 1'b1;
    @(posedge core_clk_i);
  endtask : send
endmodule : urb_tx_model

// File: test/urb_receiver_tb_top.sv
`timescale 1ns/1ps
module uart_receive_buffer_status_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic global_irq_en_i = 1'b1;
  logic rd_d = 1'b0;
  logic [7:0] rdata_o;
  logic rx_pin_i;
  logic rx_irq_o;
  logic pin_override_o;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int n_checks = 0;
  always #5 core_clk_i = ~core_clk_i;
  urb_receiver i_urb_receiver (.core_clk_i, .rst_n_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .sample_en_i(1'b1), .rx_pin_i,
    .global_irq_en_i, .rx_irq_o, .pin_override_o);
  urb_tx_model i_urb_tx_model (.core_clk_i, .line_o(rx_pin_i));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic w(input logic [1:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : w
  task automatic r(input logic [1:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk_i);
    rd_i <= 1'b0;
  endtask : r
  // read data stands only in the cycle after the strobe
  always @(posedge core_clk_i) begin
    rd_d <= rd_i;
    if (rd_d) chk(rdata_o, exp_q.pop_front());
  end
  task automatic summarize;
    if (bad_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
  initial begin
    logic [7:0] d [4];
    void'($urandom(52));
    foreach (d[k]) d[k] = 8'($urandom);
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    r(2'h2, 8'h06);
    r(2'h0, 8'h00);
    w(2'h1, 8'h90);
    i_urb_tx_model.send(d[0], 1'b0, 1'b1, 1'b0);
    repeat (2) @(negedge core_clk_i);
    chk(8'(pin_override_o), 8'h01);
    chk(8'(rx_irq_o), 8'h01);
    @(posedge core_clk_i);
    global_irq_en_i <= 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk(8'(rx_irq_o), 8'h00);
    @(posedge core_clk_i);
    global_irq_en_i <= 1'b1;
    r(2'h0, 8'h80);
    r(2'h1, 8'h90);
    r(2'h3, d[0]);
    r(2'h0, 8'h00);
    i_urb_tx_model.send(d[1], 1'b0, 1'b0, 1'b0);
    r(2'h0, 8'h90);
    r(2'h3, d[1]);
    // even then odd checking: one good frame, one bad frame
    for (int o = 0; o < 2; o++) begin
      w(2'h2, o[0] ? 8'h36 : 8'h26);
      i_urb_tx_model.send(d[2], ^d[2] ^ o[0], 1'b1, 1'b1);
      i_urb_tx_model.send(d[3], ~^d[3] ^ o[0], 1'b1, 1'b1);
      r(2'h0, 8'h80);
      r(2'h3, d[2]);
      r(2'h0, 8'h84);
      r(2'h3, d[3]);
    end
    i_urb_tx_model.send(d[0], ^d[0], 1'b1, 1'b1);
    w(2'h2, 8'h06);
    r(2'h0, 8'h80);
    r(2'h3, d[0]);
    // five-bit characters: upper bits read back as zero
    w(2'h2, 8'h00);
    i_urb_tx_model.send(d[1] | 8'he0, 1'b0, 1'b1, 1'b0);
    r(2'h0, 8'h80);
    r(2'h3, d[1] & 8'h1f);
    w(2'h2, 8'h06);
    // four frames: third waits in the holder, fourth replaces it
    foreach (d[k]) i_urb_tx_model.send(d[k], 1'b0, 1'b1, 1'b0);
    r(2'h0, 8'h80);
    r(2'h3, d[0]);
    r(2'h3, d[1]);
    r(2'h0, 8'h88);
    r(2'h3, d[3]);
    r(2'h0, 8'h00);
    i_urb_tx_model.send(d[2], 1'b0, 1'b1, 1'b0);
    r(2'h0, 8'h80);
    r(2'h3, d[2]);
    i_urb_tx_model.send(d[0], 1'b0, 1'b1, 1'b0);
    i_urb_tx_model.send(d[1], 1'b0, 1'b1, 1'b0);
    fork
      i_urb_tx_model.send(d[2], 1'b0, 1'b1, 1'b0);
      begin
        repeat (80) @(posedge core_clk_i);
        w(2'h1, 8'h00);
        r(2'h0, 8'h00);
      end
    join
    @(negedge core_clk_i);
    chk(8'(pin_override_o), 8'h00);
    chk(8'(rx_irq_o), 8'h00);
    w(2'h0, 8'h00);
    w(2'h1, 8'h90);
    r(2'h0, 8'h00);
    summarize();
  end
endmodule : uart_receive_buffer_status_tb_top
